// >>> core/jie_exec.sv
// Overview of operation
// RQ1: a jump is two words, EFh plus literal bits 7..0, then prefix Fh plus literal bits 19..8; the code never checks the Fh prefix.
// RQ2: a jump loads the 20-bit literal into pc bits 20..1 and leaves every flag alone.
// RQ3: a jump takes two cycles, low byte in Q2, high bits and pc write in Q4, then an idle cycle.
// RQ4: opcode 001010 with dest bit, bank bit and 8-bit address increments that register.
// RQ5: dest bit 0 sends the result to the accumulator, dest bit 1 back to the register.
// RQ6: bank bit 0 selects the fixed access bank, bank bit 1 pairs the bank pointer with the address.
// RQ7: with bank bit 0 and extended mode on, addresses up to 5Fh are offsets from the index base.
// RQ8: the increment sets carry, half carry, negative, overflow and zero; FFh wraps with Z, C, DC.
// RQ9: the increment is one word, one cycle: decode Q1, read Q2, compute Q3, write Q4.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
module jie_exec import jie_pkg::*; (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire logic [15:0] instr_word_in,
   input wire logic [15:0] next_word_in,
   input wire logic [11:0] index_base_in,
   input wire logic [7:0] dmem_rdata_in,
   output logic [11:0] dmem_addr_out,
   output logic dmem_rd_out,
   output logic dmem_wr_out,
   output logic [7:0] dmem_wdata_out,
   output logic [20:0] pc_out,
   output logic [7:0] acc_out,
   output logic [4:0] flags_out,
   output logic [1:0] phase_out,
   output logic idle_out
);
   logic [1:0] q_r;
   jie_state_type state_r;
   logic [15:0] ir_r;
   logic [7:0] lit_lo_r;
   logic [7:0] opnd_r;
   logic [20:0] pc_r;
   logic [7:0] acc_r;
   logic [4:0] flags_r;
   logic [11:0] dmem_addr_r;
   logic dmem_rd_r;
   logic dmem_wr_r;
   logic [7:0] dmem_wdata_r;
   logic ext_r;
   logic [3:0] bank_r;
   logic wait_r;
   logic [31:0] readdata_r;
   logic [7:0] alu_result;
   logic [4:0] alu_flags;
   logic bus_wr;
   logic acc_wr;

   assign bus_wr = avs_write_in & ~wait_r;
   assign acc_wr = bus_wr && avs_address_in == REG_ACC && avs_byteenable_in[0];

   jie_inc_alu u_alu (
      .opnd_in(opnd_r),
      .result_out(alu_result),
      .flags_out(alu_flags)
   );

   // quarter phase counter, free running
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q_r <= PH_Q1;
      end else begin
         q_r <= q_r + 2'h1;
      end
   end

   // instruction register, cleared during the idle cycle
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ir_r <= WORD_RST;
      end else if (q_r == PH_Q1) begin
         ir_r <= (state_r == ST_EXEC) ? instr_word_in : WORD_RST; // RQ3
      end
   end

   // low literal byte taken in Q2
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         lit_lo_r <= 8'h00;
      end else if (q_r == PH_Q2 && is_jump(ir_r)) begin
         lit_lo_r <= ir_r[7:0]; // RQ1
      end
   end

   // pc write in Q4 and cycle sequencing
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pc_r <= PC_RST;
         state_r <= ST_EXEC;
      end else if (q_r == PH_Q4) begin
         if (is_jump(ir_r)) begin
            pc_r <= {next_word_in[11:0], lit_lo_r, 1'b0}; // RQ2
            state_r <= ST_IDLE; // RQ3
         end else if (state_r == ST_IDLE) begin
            state_r <= ST_EXEC;
         end else begin
            pc_r <= pc_r + PC_STEP;
         end
      end
   end

   // data read issued for Q2, operand captured at end of Q2
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dmem_rd_r <= 1'b0;
         dmem_addr_r <= 12'h000;
         opnd_r <= 8'h00;
      end else begin
         case (q_r)
            PH_Q1: begin
               if (state_r == ST_EXEC && is_inc(instr_word_in)) begin
                  dmem_rd_r <= 1'b1; // RQ9
                  dmem_addr_r <= data_addr(instr_word_in, bank_r, ext_r, index_base_in); // RQ6 RQ7
               end
            end
            PH_Q2: begin
               dmem_rd_r <= 1'b0;
               if (is_inc(ir_r)) begin
                  opnd_r <= dmem_rdata_in; // RQ4
               end
            end
            default: begin
               dmem_rd_r <= 1'b0;
            end
         endcase
      end
   end

   // register write back during Q4
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dmem_wr_r <= 1'b0;
         dmem_wdata_r <= 8'h00;
      end else if (q_r == PH_Q3 && is_inc(ir_r) && ir_r[DEST_BIT]) begin
         dmem_wr_r <= 1'b1; // RQ5
         dmem_wdata_r <= alu_result;
      end else begin
         dmem_wr_r <= 1'b0;
      end
   end

   // accumulator: core write in Q4 wins over the bus
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_r <= ACC_RST;
      end else if (q_r == PH_Q4 && is_inc(ir_r) && !ir_r[DEST_BIT]) begin
         acc_r <= alu_result; // RQ5
      end else if (acc_wr) begin
         acc_r <= avs_writedata_in[7:0];
      end
   end

   // flags change only on an increment
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flags_r <= FLAGS_RST;
      end else if (q_r == PH_Q4 && is_inc(ir_r)) begin
         flags_r <= alu_flags; // RQ8
      end
   end

   // control register, byte lanes 0 and 1
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ext_r <= 1'b0;
         bank_r <= BANK_RST;
      end else if (bus_wr && avs_address_in == REG_CTRL) begin
         if (avs_byteenable_in[0]) begin
            ext_r <= avs_writedata_in[CTRL_EXT_BIT]; // RQ7
         end
         if (avs_byteenable_in[1]) begin
            bank_r <= avs_writedata_in[CTRL_BANK_LSB +: 4]; // RQ6
         end
      end
   end

   // waitrequest drops one cycle after a request
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~((avs_read_in | avs_write_in) & wait_r);
      end
   end

   // read data, unmapped reads give zero
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         readdata_r <= 32'h0000_0000;
      end else if (avs_read_in && wait_r) begin
         case (avs_address_in)
            REG_CTRL: readdata_r <= {20'h0_0000, bank_r, 7'h00, ext_r};
            REG_STATUS: readdata_r <= {22'h00_0000, state_r == ST_IDLE, q_r == PH_Q1, 3'h0, flags_r};
            REG_PC: readdata_r <= {11'h000, pc_r};
            REG_ACC: readdata_r <= {24'h00_0000, acc_r};
            default: readdata_r <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_readdata_out = readdata_r;
   assign avs_waitrequest_out = wait_r;
   assign dmem_addr_out = dmem_addr_r;
   assign dmem_rd_out = dmem_rd_r;
   assign dmem_wr_out = dmem_wr_r;
   assign dmem_wdata_out = dmem_wdata_r;
   assign pc_out = pc_r;
   assign acc_out = acc_r;
   assign flags_out = flags_r;
   assign phase_out = q_r;
   assign idle_out = state_r;

   // checks
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_jump_q4;
      q_r == PH_Q4 && is_jump(ir_r);
   endsequence

   sequence s_inc_decode;
      q_r == PH_Q1 && state_r == ST_EXEC && is_inc(instr_word_in);
   endsequence

   // first idle quarter: pc has only just been loaded by the jump
   sequence s_idle_quarter;
      state_r == ST_IDLE && !dmem_rd_r && !dmem_wr_r;
   endsequence

   // later idle quarters: pc must not move at all
   sequence s_idle_still;
      state_r == ST_IDLE && !dmem_rd_r && !dmem_wr_r && $stable(pc_r);
   endsequence

   a_jump_pc_load: assert property ( // RQ2
      s_jump_q4 |=> pc_r == {$past(next_word_in[11:0]), $past(lit_lo_r), 1'b0})
      else $error("jump did not load pc from literal");

   a_jump_lit_low: assert property ( // RQ1
      q_r == PH_Q1 && state_r == ST_EXEC && is_jump(instr_word_in)
      |=> ##1 lit_lo_r == $past(instr_word_in[7:0], 2))
      else $error("jump low literal not taken in Q2");

   a_jump_idle_cycle: assert property ( // RQ3
      s_jump_q4 |=> s_idle_quarter ##1 s_idle_still [*3] ##1 state_r == ST_EXEC && $stable(pc_r))
      else $error("jump second cycle not idle");

   a_jump_flags_hold: assert property ( // RQ2
      q_r == PH_Q1 && state_r == ST_EXEC && is_jump(instr_word_in) |=> $stable(flags_r) [*8])
      else $error("flags changed during jump");

   a_inc_read_q2: assert property ( // RQ9
      s_inc_decode |=> dmem_rd_r ##1 !dmem_rd_r && !dmem_wr_r ##1 !dmem_rd_r)
      else $error("increment read not in Q2");

   a_bank_select: assert property ( // RQ6
      s_inc_decode and instr_word_in[BANK_BIT]
      |=> dmem_addr_r == {$past(bank_r), $past(instr_word_in[7:0])})
      else $error("bank pointer not used");

   a_indexed_offset: assert property ( // RQ7
      s_inc_decode and !instr_word_in[BANK_BIT] && ext_r && instr_word_in[7:0] <= INDEX_LIMIT
      |=> dmem_addr_r == 12'($past(index_base_in) + {4'h0, $past(instr_word_in[7:0])}))
      else $error("indexed offset address wrong");

   a_inc_to_reg: assert property ( // RQ5
      q_r == PH_Q2 && is_inc(ir_r) && ir_r[DEST_BIT]
      |=> ##1 dmem_wr_r && dmem_wdata_r == 8'($past(dmem_rdata_in, 2) + 8'h01))
      else $error("increment result not written to register");

   a_inc_to_acc: assert property ( // RQ5
      q_r == PH_Q2 && is_inc(ir_r) && !ir_r[DEST_BIT]
      |=> ##1 !dmem_wr_r ##1 acc_r == 8'($past(dmem_rdata_in, 3) + 8'h01))
      else $error("increment result not placed in accumulator");

   a_wrap_flags: assert property ( // RQ8
      q_r == PH_Q3 && is_inc(ir_r) && opnd_r == 8'hFF
      |=> ##1 flags_r[FLG_Z] && flags_r[FLG_C] && flags_r[FLG_DC] && !flags_r[FLG_N])
      else $error("wrap of FFh did not set Z, C, DC");

   // bank bit clear outside indexed mode: split access bank
   a_access_bank: assert property ( // RQ6
      s_inc_decode and !instr_word_in[BANK_BIT]
      && !(ext_r && instr_word_in[7:0] <= INDEX_LIMIT)
      |=> dmem_addr_r == {($past(instr_word_in[7:0]) >= ACC_SPLIT) ? ACC_HI_PAGE : ACC_LO_PAGE,
                          $past(instr_word_in[7:0])})
      else $error("access bank address wrong");

   // sign change on 7Fh raises overflow and negative
   a_sign_flags: assert property ( // RQ8
      q_r == PH_Q3 && is_inc(ir_r) && opnd_r == 8'h7F
      |=> ##1 flags_r[FLG_OV] && flags_r[FLG_N] && !flags_r[FLG_Z] && !flags_r[FLG_C])
      else $error("7Fh increment did not set OV and N");

   // a jump touches no data memory from its Q2 through the first idle quarter
   a_jump_no_data: assert property ( // RQ3
      q_r == PH_Q1 && state_r == ST_EXEC && is_jump(instr_word_in)
      |=> (!dmem_rd_r && !dmem_wr_r) [*4])
      else $error("data strobe during jump");

   // single-word instructions step pc by one word
   a_word_step: assert property ( // RQ9
      q_r == PH_Q4 && state_r == ST_EXEC && !is_jump(ir_r)
      |=> pc_r == 21'($past(pc_r) + PC_STEP))
      else $error("pc did not step one word");
endmodule

// >>> core/jie_pkg.sv
package jie_pkg;
   // quarter phases of one instruction cycle
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   // opcode patterns and instruction fields
   localparam logic [7:0] OPC_JUMP = 8'hEF;
   localparam logic [5:0] OPC_INC = 6'h0A;
   localparam logic [3:0] JUMP_PREFIX = 4'hF;
   localparam int OPC_JUMP_LSB = 8;
   localparam int OPC_INC_LSB = 10;
   localparam int PREFIX_LSB = 12;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;

   // data addressing
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_HI_PAGE = 4'hF;
   localparam logic [3:0] ACC_LO_PAGE = 4'h0;

   // flag bit positions
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;

   // register map, byte addresses
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_PC = 4'h8;
   localparam logic [3:0] REG_ACC = 4'hC;
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_BANK_LSB = 8;

   // reset values and steps
   localparam logic [20:0] PC_RST = 21'h00_0000;
   localparam logic [20:0] PC_STEP = 21'h00_0002;
   localparam logic [4:0] FLAGS_RST = 5'h00;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] BANK_RST = 4'h0;
   localparam logic [15:0] WORD_RST = 16'h0000;

   typedef enum logic {ST_EXEC, ST_IDLE} jie_state_type;

   // first word of the two-word jump
   function automatic logic is_jump(input logic [15:0] w);
      return w[15:OPC_JUMP_LSB] == OPC_JUMP;
   endfunction

   // single-word increment
   function automatic logic is_inc(input logic [15:0] w);
      return w[15:OPC_INC_LSB] == OPC_INC;
   endfunction

   // data address from bank bit, bank pointer and indexed mode
   function automatic logic [11:0] data_addr(input logic [15:0] w, input logic [3:0] bank,
                                             input logic ext, input logic [11:0] base);
      logic [7:0] f;
      f = w[7:0];
      if (w[BANK_BIT]) begin
         return {bank, f};
      end else if (ext && f <= INDEX_LIMIT) begin
         return 12'(base + {4'h0, f});
      end else if (f >= ACC_SPLIT) begin
         return {ACC_HI_PAGE, f};
      end else begin
         return {ACC_LO_PAGE, f};
      end
   endfunction
endpackage

// >>> core/jie_inc_alu.sv
module jie_inc_alu import jie_pkg::*; (
   input wire logic [7:0] opnd_in,
   output logic [7:0] result_out,
   output logic [4:0] flags_out
);
   logic [8:0] sum;
   logic [4:0] half;

   // add one, carry out of bit 7 and bit 3
   always_comb begin
      sum = {1'b0, opnd_in} + 9'h001;
      half = {1'b0, opnd_in[3:0]} + 5'h01;
      result_out = sum[7:0];
      flags_out = FLAGS_RST;
      flags_out[FLG_C] = sum[8]; // RQ8
      flags_out[FLG_DC] = half[4]; // RQ8
      flags_out[FLG_Z] = sum[7:0] == 8'h00; // RQ8
      flags_out[FLG_OV] = ~opnd_in[7] & sum[7]; // RQ8
      flags_out[FLG_N] = sum[7]; // RQ8
   end
endmodule

// >>> verification/jie_exec_bench.sv
module jie_exec_bench import jie_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [3:0] av_addr = 4'h0;
   logic av_read = 1'b0;
   logic av_write = 1'b0;
   logic [31:0] av_wdata = 32'h0000_0000;
   logic [3:0] av_be = 4'h0;
   logic [31:0] av_rdata;
   logic av_wait;
   logic [15:0] instr_word_in = 16'h0000;
   logic [15:0] next_word_in = 16'h0000;
   logic [11:0] index_base_in = 12'h100;
   logic [7:0] dmem_rdata_in = 8'h00;
   logic [11:0] dmem_addr_out;
   logic dmem_rd_out;
   logic dmem_wr_out;
   logic [7:0] dmem_wdata_out;
   logic [20:0] pc_out;
   logic [7:0] acc_out;
   logic [4:0] flags_out;
   logic [1:0] phase_out;
   logic idle_out;
   int fail_count = 0;
   int tests_run = 0;
   int idle_n;
   logic rs;
   logic ws;
   logic [11:0] as;
   logic [7:0] wd;
   logic [31:0] rdv;

   jie_exec u_dut (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .avs_address_in(av_addr), .avs_read_in(av_read), .avs_write_in(av_write),
      .avs_writedata_in(av_wdata), .avs_byteenable_in(av_be),
      .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait),
      .instr_word_in(instr_word_in), .next_word_in(next_word_in),
      .index_base_in(index_base_in), .dmem_rdata_in(dmem_rdata_in),
      .dmem_addr_out(dmem_addr_out), .dmem_rd_out(dmem_rd_out), .dmem_wr_out(dmem_wr_out),
      .dmem_wdata_out(dmem_wdata_out), .pc_out(pc_out), .acc_out(acc_out),
      .flags_out(flags_out), .phase_out(phase_out), .idle_out(idle_out)
   );

   // 50 MHz clock
   initial begin
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   // verdict and end of run
   task automatic end_sim;
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // compare seen against expected
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one bus cycle, held until waitrequest samples low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge sys_clk_in);
      av_read <= !wr;
      av_write <= wr;
      av_addr <= a;
      av_wdata <= d;
      av_be <= be;
      do @(posedge sys_clk_in); while (av_wait !== 1'b0);
      rdv = av_rdata;
      av_read <= 1'b0;
      av_write <= 1'b0;
   endtask

   // present one word for a full quarter group, capture strobes
   task automatic instr(input logic [15:0] w, input logic [15:0] nw, input logic [7:0] rd);
      do @(negedge sys_clk_in); while (phase_out !== PH_Q4);
      @(posedge sys_clk_in);
      instr_word_in <= w;
      next_word_in <= nw;
      dmem_rdata_in <= rd;
      repeat (2) @(negedge sys_clk_in);
      rs = dmem_rd_out;
      as = dmem_addr_out;
      @(posedge sys_clk_in);
      dmem_rdata_in <= ~rd; // read data no longer held
      repeat (2) @(negedge sys_clk_in);
      ws = dmem_wr_out;
      wd = dmem_wdata_out;
      @(posedge sys_clk_in);
      instr_word_in <= 16'h0000;
      @(negedge sys_clk_in);
   endtask

   // increment with expected address, destination and flags
   task automatic t_inc(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] ea,
                        input logic ew, input logic [7:0] ev, input logic [4:0] ef);
      instr(w, 16'h0000, rd);
      chk("rd strobe", rs, 1'b1);
      chk("phase", phase_out, PH_Q1);
      chk("data addr", as, ea);
      chk("wr strobe", ws, ew);
      if (ew) begin
         chk("wdata", wd, ev);
      end else begin
         chk("acc", acc_out, ev);
      end
      chk("flags", flags_out, ef);
   endtask

   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      @(negedge sys_clk_in);
      chk("pc rst", pc_out, PC_RST);
      chk("acc rst", acc_out, ACC_RST);
      chk("flags rst", flags_out, FLAGS_RST);
      chk("idle rst", idle_out, 1'b0);
      // bank 3, then lane 0 only sets extended mode
      bus(1'b1, REG_CTRL, 32'h0000_0300, 4'hF);
      bus(1'b1, REG_CTRL, 32'h0000_0501, 4'h1);
      bus(1'b0, REG_CTRL, 32'h0000_0000, 4'hF);
      chk("ctrl", rdv[11:0], 12'h301);
      bus(1'b0, 4'h2, 32'h0000_0000, 4'hF);
      chk("unmapped", rdv, 32'h0000_0000);
      bus(1'b1, REG_ACC, 32'h0000_0055, 4'hF);
      bus(1'b0, REG_ACC, 32'h0000_0000, 4'hF);
      chk("acc reg", rdv[7:0], 8'h55);
      t_inc(16'h2B10, 8'hFF, 12'h310, 1'b1, 8'h00, 5'h07);
      bus(1'b0, REG_STATUS, 32'h0000_0000, 4'hF);
      chk("status", rdv[4:0], 5'h07);
      t_inc(16'h2870, 8'h7F, 12'hF70, 1'b0, 8'h80, 5'h1A);
      t_inc(16'h2820, 8'h0E, 12'h120, 1'b0, 8'h0F, 5'h00);
      bus(1'b1, REG_CTRL, 32'h0000_0000, 4'h1);
      t_inc(16'h2820, 8'h0F, 12'h020, 1'b0, 8'h10, 5'h02);
      // two-word jump, then the idle group
      instr(16'hEF12, 16'hF345, 8'hAA);
      chk("jump pc", pc_out, 21'h06_8A24);
      chk("jump flags", flags_out, 5'h02);
      chk("jump wr", ws, 1'b0);
      chk("jump rd", rs, 1'b0);
      idle_n = 0;
      repeat (6) begin
         if (idle_out === 1'b1) idle_n++;
         @(negedge sys_clk_in);
      end
      chk("idle cycles", idle_n, 4);
      chk("pc held", pc_out, 21'h06_8A24);
      end_sim;
   end

   // hang guard, far beyond the hundred or so cycles needed
   initial begin
      repeat (3000) @(posedge sys_clk_in);
      fail_count++;
      end_sim;
   end
endmodule
